// File: design/asm_cfg.svh
`ifndef ASM_CFG_SVH
`define ASM_CFG_SVH

// result word layout
`define ASM_RES_W 14
`define ASM_RES_MSB 13
`define ASM_CODE_ZERO 14'h0000
`define ASM_CODE_MID 14'h2000
`define ASM_CODE_FULL 14'h3fff

// clocking of the control domain
`define ASM_CLK_MHZ 25
// internal conversion time, nanoseconds
`define ASM_CONV_NS 2200
// conversion time in control clock cycles, least time rounded up
`define ASM_CONV_CYC ((`ASM_CONV_NS * `ASM_CLK_MHZ + 999) / 1000)

// serial frame lengths in link clock falling edges
`define ASM_BITS_PLAIN 14
`define ASM_BITS_BUSY 15

// reset values
`define ASM_RST_RESULT 14'h0000
`define ASM_RST_CNT 5'h00

`endif

// File: design/asm_pkg.sv
package asm_pkg;

	// conversion sequencing
	typedef enum logic [1:0] {
		ASM_IDLE,
		ASM_CONVERT,
		ASM_ACQUIRE
	} asm_state_t;

	// interface mode chosen at each conversion start
	typedef enum logic {
		ASM_MODE_SELECT,
		ASM_MODE_CHAIN
	} asm_mode_t;

endpackage : asm_pkg

// File: design/asm_sync.sv
`timescale 1ns/1ps

// two-flop level synchroniser; only the second stage is ever read
module asm_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// levels in and out
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	logic [W-1:0] meta_r; // first stage, read only by the second stage
	logic [W-1:0] sync_r; // second stage

	// both stages clear to zero under reset
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= d_i;
			sync_r <= meta_r;
		end
	end

	assign q_o = sync_r;

endmodule : asm_sync

// File: design/asm_top.sv
`timescale 1ns/1ps
`include "asm_cfg.svh"

module asm_top
	import asm_pkg::*;
#(
	parameter int RES_W = `ASM_RES_W,
	parameter int IN_W = 16,
	parameter int CONV_CYC = `ASM_CONV_CYC
) (
	// control clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// serial link clock from the host
	input wire logic sck_i,
	// host pins
	input wire logic convert_strobe_i,
	input wire logic serial_in_select_i,
	output logic serial_out_o,
	output logic serial_out_oe_o,
	// analog core: signed difference in lsb units, sampled at end of conversion
	input wire logic signed [IN_W-1:0] conv_value_i,
	// analog core control and status
	output logic conv_active_o,
	output logic conv_power_o,
	output logic [RES_W-1:0] result_o,
	output logic mode_chain_o,
	output logic busy_en_o
);

	localparam logic [4:0] BITS_PLAIN = 5'(`ASM_BITS_PLAIN);
	localparam logic [4:0] BITS_BUSY = 5'(`ASM_BITS_BUSY);
	localparam int CW = $clog2(CONV_CYC + 1);
	localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYC - 1);

	// ---------------------------------------------------------------
	// control domain: pin levels brought in through two flops
	// ---------------------------------------------------------------

	logic [2:0] pins_raw; // strobe, serial input, link clock level
	logic [2:0] pins_s; // synchronised copies
	logic strobe_s; // synchronised strobe
	logic sdi_s; // synchronised serial input
	logic sck_s; // synchronised link clock level

	assign pins_raw = {convert_strobe_i, serial_in_select_i, sck_i};

	asm_sync #(
		.W(3)
	) u_pin_sync (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.d_i(pins_raw),
		.q_o(pins_s)
	);

	assign strobe_s = pins_s[2];
	assign sdi_s = pins_s[1];
	assign sck_s = pins_s[0];

	logic strobe_d_r; // previous strobe level for edge detect
	logic sdi_d_r; // serial input level one sample before the strobe was seen high
	wire strobe_rise = strobe_s && !strobe_d_r; // conversion start event

	// edge detector runs on the synchronised level only
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			strobe_d_r <= 1'b0;
			sdi_d_r <= 1'b1;
		end else begin
			strobe_d_r <= strobe_s;
			// delayed copy: an input tied to the strobe still reads low here
			sdi_d_r <= sdi_s;
		end
	end

	// ---------------------------------------------------------------
	// conversion sequencer
	// ---------------------------------------------------------------

	asm_state_t state_r; // current phase
	asm_state_t state_nxt; // next phase
	logic [CW-1:0] tmr_r; // cycles spent converting
	logic [CW-1:0] tmr_nxt;
	wire conv_end = (state_r == ASM_CONVERT) && (tmr_r == CONV_LAST);

	// a started conversion always runs to the end, whatever the strobe does
	always_comb begin
		state_nxt = state_r;
		tmr_nxt = tmr_r;
		case (state_r)
			ASM_IDLE, ASM_ACQUIRE: begin
				tmr_nxt = '0;
				if (strobe_rise) begin
					state_nxt = ASM_CONVERT;
				end
			end
			ASM_CONVERT: begin
				// timed by this clock alone, the link clock plays no part
				tmr_nxt = tmr_r + CW'(1);
				if (conv_end) begin
					state_nxt = ASM_ACQUIRE;
					tmr_nxt = '0;
				end
			end
			default: begin
				state_nxt = ASM_IDLE;
				tmr_nxt = '0;
			end
		endcase
	end

	// phase and timer registers
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_r <= ASM_IDLE;
			tmr_r <= '0;
		end else begin
			state_r <= state_nxt;
			tmr_r <= tmr_nxt;
		end
	end

	// power only during the conversion phase, so no command is needed between samples
	assign conv_active_o = (state_r == ASM_CONVERT);
	assign conv_power_o = (state_r == ASM_CONVERT);

	// ---------------------------------------------------------------
	// result coding
	// ---------------------------------------------------------------

	localparam logic signed [IN_W-1:0] FULL_S = IN_W'(`ASM_CODE_FULL);

	wire under_rng = conv_value_i < 0; // below ground
	wire over_rng = conv_value_i > FULL_S; // above reference span
	wire [RES_W-1:0] in_code = conv_value_i[RES_W-1:0];
	// saturate rather than wrap: a wrapped code would look like a small reading
	wire [RES_W-1:0] code_sel = under_rng ? RES_W'(`ASM_CODE_ZERO) :
		over_rng ? RES_W'(`ASM_CODE_FULL) : in_code;

	logic [RES_W-1:0] result_r; // straight binary result word
	logic done_r; // result valid since last conversion end
	logic mode_chain_r; // mode latched at conversion start
	logic busy_chain_r; // chain busy request caught at start
	logic busy_en_r; // start bit enabled for this result

	// result captured at conversion end as plain binary
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			result_r <= `ASM_RST_RESULT;
		end else if (conv_end) begin
			result_r <= code_sel;
		end
	end

	// mode chosen from the serial input level at the strobe rise;
	// with the input wired to the strobe the hold keeps it low here
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode_chain_r <= 1'b0;
			busy_chain_r <= 1'b0;
		end else if (strobe_rise && state_r != ASM_CONVERT) begin
			// the input is sampled as it stood before the rise
			mode_chain_r <= !sdi_d_r;
			busy_chain_r <= sck_s;
		end
	end

	// busy start bit decided for each result
	wire busy_sel = !strobe_s || !sdi_s;
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			busy_en_r <= 1'b0;
		end else if (conv_end) begin
			busy_en_r <= mode_chain_r ? busy_chain_r : busy_sel;
		end
	end

	// result validity; a new start wins over an old result
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			done_r <= 1'b0;
		end else if (strobe_rise && state_r != ASM_CONVERT) begin
			done_r <= 1'b0;
		end else if (conv_end) begin
			done_r <= 1'b1;
		end
	end

	assign result_o = result_r;
	assign mode_chain_o = mode_chain_r;
	assign busy_en_o = busy_en_r;

	// ---------------------------------------------------------------
	// link domain: readback on the host's serial clock
	// ---------------------------------------------------------------

	// the frame is open while the strobe is low (3-wire, chain) or the
	// serial input is low with the strobe high (4-wire select)
	wire frame_sel = !(convert_strobe_i && serial_in_select_i);
	wire frame_chain = !convert_strobe_i;
	wire frame_on = mode_chain_r ? frame_chain : frame_sel;
	// the link clock stops between frames, so the frame itself resets
	// the link logic asynchronously instead of waiting for an edge
	wire link_rstn = rstn_i && frame_on;

	logic [4:0] bit_cnt_r; // falling edges seen this frame
	logic [RES_W-1:0] chain_r; // chain shift register
	logic [4:0] frame_len; // edges before release

	assign frame_len = busy_en_r ? BITS_BUSY : BITS_PLAIN;

	// result, mode and busy flags can still change while a frame is open,
	// so the host only clocks bits after the conversion has finished
	always_ff @(negedge sck_i or negedge link_rstn) begin
		if (!link_rstn) begin
			bit_cnt_r <= `ASM_RST_CNT;
		end else if (bit_cnt_r != frame_len) begin
			bit_cnt_r <= bit_cnt_r + 5'h01;
		end
	end

	// chain shift: first edge (second with the busy start bit) loads below the msb and takes the
	// upstream bit, later edges move data along toward the output
	always_ff @(negedge sck_i or negedge link_rstn) begin
		if (!link_rstn) begin
			chain_r <= '0;
		end else if (bit_cnt_r == 5'h00 && !busy_en_r) begin
			chain_r <= {result_r[RES_W-2:0], serial_in_select_i};
		end else if (bit_cnt_r == 5'h01 && busy_en_r) begin
			chain_r <= {result_r[RES_W-2:0], serial_in_select_i};
		end else begin
			chain_r <= {chain_r[RES_W-2:0], serial_in_select_i};
		end
	end

	// ---------------------------------------------------------------
	// serial output selection
	// ---------------------------------------------------------------

	wire [4:0] data_idx = busy_en_r ? bit_cnt_r - 5'h01 : bit_cnt_r; // bit position
	wire start_slot = busy_en_r && (bit_cnt_r == 5'h00); // busy start bit
	wire first_slot = (data_idx == 5'h00); // msb slot
	// chain mode keeps driving so upstream data passes through after the result
	wire in_range = mode_chain_r || (bit_cnt_r < frame_len);
	wire [3:0] sel_bit = 4'(RES_W - 1) - data_idx[3:0]; // msb first
	wire sel_data = result_r[sel_bit];
	wire chain_data = first_slot ? result_r[RES_W-1] : chain_r[RES_W-1];
	wire data_bit = mode_chain_r ? chain_data : sel_data;

	// low start bit, giving a falling edge against a pull-up
	assign serial_out_o = start_slot ? 1'b0 : data_bit;

	// driven only with a finished result and an open frame
	assign serial_out_oe_o = done_r && frame_on && in_range;

endmodule : asm_top

// File: tb/asm_top_properties.sv
`timescale 1ns/1ps
// watches the converter pins and status; phase length is counted in helper logic
module asm_top_properties
	import asm_pkg::*;
#(
	parameter int CONV_CYC = 55
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// host pins
	input wire logic convert_strobe_i,
	input wire logic serial_in_select_i,
	input wire logic serial_out_oe_o,
	// core side
	input wire logic signed [15:0] conv_value_i,
	input wire logic conv_active_o,
	input wire logic conv_power_o,
	input wire logic [13:0] result_o,
	input wire logic mode_chain_o,
	input wire logic busy_en_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// cycles spent converting; cleared outside so each phase is measured alone
	logic [7:0] act_cnt_r;
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			act_cnt_r <= 8'h00;
		else
			act_cnt_r <= conv_active_o ? act_cnt_r + 8'h01 : 8'h00;
	end
	// end of a conversion phase
	sequence conv_end_s;
		$fell(conv_active_o);
	endsequence
	conv_len_a: assert property (conv_end_s |-> act_cnt_r == CONV_CYC)
		else $error("conversion phase length wrong");
	power_track_a: assert property (conv_power_o == conv_active_o)
		else $error("core power not tied to conversion");
	quiet_conv_a: assert property (conv_active_o |-> !serial_out_oe_o)
		else $error("output driven while converting");
	frame_close_a: assert property
		(convert_strobe_i && (mode_chain_o || serial_in_select_i) |-> !serial_out_oe_o)
		else $error("output driven with frame closed");
	clamp_low_a: assert property
		(conv_end_s ##0 (conv_value_i < 0) |-> result_o == 14'h0000)
		else $error("under-range not clamped");
	clamp_high_a: assert property
		(conv_end_s ##0 (conv_value_i > 16'sh3fff) |-> result_o == 14'h3fff)
		else $error("over-range not saturated");
	code_pass_a: assert property
		(conv_end_s ##0 (conv_value_i inside {[0:16383]}) |-> result_o == conv_value_i[13:0])
		else $error("in-range code altered");
	result_hold_a: assert property (!$fell(conv_active_o) |-> $stable(result_o))
		else $error("result moved outside conversion end");
	mode_pick_a: assert property
		($rose(conv_active_o) |-> mode_chain_o == !$past(serial_in_select_i, 5))
		else $error("mode not taken from input level");
	busy_sel_a: assert property
		(conv_end_s ##0 !mode_chain_o |->
		busy_en_o == !($past(convert_strobe_i) && $past(serial_in_select_i)))
		else $error("select busy flag wrong");
endmodule : asm_top_properties

bind asm_top asm_top_properties #(.CONV_CYC(CONV_CYC)) chk_u (.clk_i, .rstn_i,
	.convert_strobe_i, .serial_in_select_i, .serial_out_oe_o, .conv_value_i,
	.conv_active_o, .conv_power_o, .result_o, .mode_chain_o, .busy_en_o);

// File: tb/asm_host.sv
`timescale 1ns/1ps
// host model: strobe, select/data pin and a link clock that runs only inside frames
module asm_host (
	// pacing clock
	input wire logic clk_i,
	// output line as seen through the pull-up
	input wire logic line_i,
	// pins towards the converter
	output logic strobe_o,
	output logic sdi_o,
	output logic sck_o
);
	initial begin
		strobe_o = 1'b0;
		sdi_o = 1'b1;
		sck_o = 1'b0;
	end
	// levels settle well before the rise so the pick is clean
	task automatic start(input logic s0, input logic k0, input logic tie);
		@(posedge clk_i) #2;
		strobe_o = 1'b0;
		sdi_o = tie ? 1'b0 : s0;
		sck_o = k0;
		repeat (8) @(posedge clk_i);
		#2;
		strobe_o = 1'b1;
		if (tie)
			sdi_o = 1'b1;
	endtask : start
	// strobe and select levels; link clock parked low
	task automatic pins(input logic c, input logic s);
		strobe_o = c;
		sdi_o = s;
		sck_o = 1'b0;
	endtask : pins
	// 12 ns link clock burst; each bit taken while the clock is high
	task automatic clock_bits(input int n, output logic [31:0] w);
		w = 32'h0;
		repeat (n) begin
			#6 sck_o = 1'b1;
			w = {w[30:0], line_i};
			#6 sck_o = 1'b0;
		end
		#6;
	endtask : clock_bits
endmodule : asm_host

// File: tb/tb_asm_top.sv
`timescale 1ns/1ps
module tb_asm_top;
	// short conversion keeps the run brief
	localparam int CONV = 8;
	// one case: pins at rise, pins during conversion, core value, expected flags
	typedef struct packed {
		logic s0, t, k0, s1, c1, osd;
		logic [15:0] v;
		logic [13:0] code;
		logic md, bz;
	} asm_row_t;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic signed [15:0] conv_value_i = 16'sh0000;
	wire strobe, serial_in_select, sck, serial_out, oe, act, pwr, mch, bz;
	wire [13:0] res;
	wire line = oe ? serial_out : 1'b1; // pull-up on the output line
	int error_cnt = 0;
	int num_checks = 0;
	asm_row_t rows [7];
	always #20 clk_i = ~clk_i;
	asm_top #(.CONV_CYC(CONV)) dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .sck_i(sck),
		.convert_strobe_i(strobe), .serial_in_select_i(serial_in_select), .serial_out_o(serial_out),
		.serial_out_oe_o(oe), .conv_value_i(conv_value_i), .conv_active_o(act),
		.conv_power_o(pwr), .result_o(res), .mode_chain_o(mch), .busy_en_o(bz));
	asm_host host_u (.clk_i(clk_i), .line_i(line), .strobe_o(strobe), .sdi_o(serial_in_select),
		.sck_o(sck));
	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// bounded wait for the conversion flag to reach a level
	task automatic wait_lv(input logic lv);
		int n;
		n = 0;
		while (act !== lv) begin
			@(posedge clk_i);
			n++;
			if (n > 40) begin
				error_cnt++;
				finish_test();
			end
		end
	endtask : wait_lv
	initial begin
		int n;
		logic [31:0] w, exp;
		// select 3-wire, select busy, 4-wire, 4-wire busy, chain busy, chain, tied
		rows = '{{6'h26, 16'h2000, 14'h2000, 2'h0}, {6'h24, 16'hfffb, 14'h0000, 2'h1},
			{6'h27, 16'h0001, 14'h0001, 2'h0}, {6'h23, 16'h3fff, 14'h3fff, 2'h1},
			{6'h0e, 16'h7fff, 14'h3fff, 2'h3}, {6'h06, 16'h1fff, 14'h1fff, 2'h2},
			{6'h16, 16'h0000, 14'h0000, 2'h2}};
		repeat (16) @(posedge clk_i);
		#2;
		rstn_i = 1'b1;
		check({oe, act, pwr, mch, bz, res}, 32'h0); // reset levels
		foreach (rows[i]) begin
			conv_value_i = rows[i].v;
			host_u.start(rows[i].s0, rows[i].k0, rows[i].t);
			wait_lv(1'b1);
			repeat (2) @(posedge clk_i);
			#2;
			host_u.pins(rows[i].c1, rows[i].s1);
			wait_lv(1'b0);
			#2;
			check(res, rows[i].code);
			check(mch, rows[i].md);
			check(bz, rows[i].bz);
			// open the frame by strobe or by the select input
			host_u.pins(rows[i].osd & rows[i].c1, ~rows[i].osd & ~rows[i].t & rows[i].s1);
			n = (rows[i].bz ? 15 : 14) + (rows[i].md ? 14 : 0);
			// chain tail carries the upstream input level
			exp = rows[i].md ? {4'h0, rows[i].code, {14{serial_in_select}}} : {18'h0, rows[i].code};
			host_u.clock_bits(n, w);
			check(w, exp);
			if (!rows[i].md)
				check(oe, 1'b0);
			host_u.pins(1'b1, 1'b1);
			#1;
			check(oe, 1'b0);
			// a strobe-framed read ends in a strobe rise, which starts a conversion
			if (!rows[i].osd) begin
				wait_lv(1'b1);
				wait_lv(1'b0);
			end
		end
		// reset in mid-conversion drops the phase and the output at once
		host_u.start(1'b1, 1'b0, 1'b0);
		wait_lv(1'b1);
		#2;
		rstn_i = 1'b0;
		#2;
		check({oe, act, pwr}, 32'h0);
		finish_test();
	end
endmodule : tb_asm_top
